// [inc/psc_cfg.svh]
// constants of the pixel array scan control block
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH

// ************************************************************
// array geometry
// ************************************************************
`define PSC_ROWS 1024
`define PSC_COLS 1280
`define PSC_SUB_STEP 11'h004
`define PSC_FULL_STEP 11'h001
`define PSC_POS_W 11
`define PSC_PIN_W 12

// ************************************************************
// register map
// ************************************************************
`define PSC_OFS_CTRL 10'h000
`define PSC_OFS_STATUS 10'h001
`define PSC_OFS_ROWPOS 10'h002
`define PSC_OFS_COLPOS 10'h003
`define PSC_OFS_FRAMES 10'h004
`define PSC_CTRL_RST 2'h1
`define PSC_CTRL_EN_BIT 0
`define PSC_CTRL_SUB_BIT 1
`define PSC_STAT_EARLY_LSB 8
`define PSC_ROWPOS_RIGHT_LSB 16

`endif

// [inc/psc_pkg.sv]
// types of the pixel array scan control block
`include "psc_cfg.svh"

package psc_pkg;

    typedef struct packed {
        logic right_row_sync_n;
        logic right_row_shift_clock;
        logic left_row_sync_n;
        logic left_row_shift_clock;
        logic column_sync_n;
        logic column_shift_clock;
        logic row_select;
        logic row_reset;
        logic row_side_left;
        logic column_track_hold;
        logic column_amp_calibrate;
        logic viewfinder_subsample;
    } psc_pins_t;

    typedef struct packed {
        logic eos_n;
        logic done;
        logic [`PSC_POS_W-1:0] pos;
    } psc_ptr_st_t;

    typedef enum logic [3:0] {
        PSC_SCAN  = 4'h1,
        PSC_WAIT  = 4'h2,
        PSC_PULSE = 4'h4,
        PSC_DONE  = 4'h8
    } psc_ptr_state_t;

endpackage : psc_pkg

// [core/psc_sync.sv]
// two-flop synchroniser for the scan control pins
`include "psc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module psc_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [`PSC_PIN_W-1:0] din,
    output logic [`PSC_PIN_W-1:0] dout
);

    logic [`PSC_PIN_W-1:0] meta_r;

    // idle pin levels: syncs high, strobes low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 12'hA80;
            dout <= 12'hA80;
        end else if (ce) begin
            meta_r <= din;
            dout <= meta_r;
        end
    end

endmodule : psc_sync

`default_nettype wire

// [core/psc_pointer.sv]
// one row or column pointer with end-of-scan flag
`include "psc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module psc_pointer #(
    parameter int LENGTH = `PSC_ROWS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic enable,
    input wire logic subsample,
    input wire logic sync_n,
    input wire logic shift_clock,
    output psc_pkg::psc_ptr_st_t st
);

    localparam logic [`PSC_POS_W-1:0] LEN = `PSC_POS_W'(LENGTH);

    psc_pkg::psc_ptr_state_t state_r;
    psc_pkg::psc_ptr_state_t state_nxt;
    logic [`PSC_POS_W-1:0] pos_nxt;
    logic [`PSC_POS_W-1:0] step;
    logic [`PSC_POS_W-1:0] last;
    logic clk_q_r;
    logic fall;
    logic rise;

    // edges seen on the synchronised pin level
    assign fall = clk_q_r && !shift_clock;
    assign rise = !clk_q_r && shift_clock;
    assign step = subsample ? `PSC_SUB_STEP : `PSC_FULL_STEP;
    assign last = LEN - step;

    always_comb begin
        state_nxt = state_r;
        pos_nxt = st.pos;
        if (!sync_n) begin
            state_nxt = psc_pkg::PSC_SCAN;
            pos_nxt = '0;
        end else begin
            case (state_r)
                psc_pkg::PSC_SCAN: begin
                    if (fall && enable) begin
                        if (st.pos >= last) begin
                            state_nxt = psc_pkg::PSC_WAIT;
                        end else begin
                            pos_nxt = st.pos + step;
                        end
                    end
                end
                psc_pkg::PSC_WAIT: begin
                    if (rise) begin
                        state_nxt = psc_pkg::PSC_PULSE;
                    end
                end
                psc_pkg::PSC_PULSE: begin
                    if (fall) begin
                        state_nxt = psc_pkg::PSC_DONE;
                    end
                end
                psc_pkg::PSC_DONE: begin
                    state_nxt = psc_pkg::PSC_DONE;
                end
                default: begin
                    state_nxt = psc_pkg::PSC_SCAN;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= psc_pkg::PSC_SCAN;
            st <= '{eos_n: 1'b1, done: 1'b0, pos: '0};
            clk_q_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            st.pos <= pos_nxt;
            st.eos_n <= (state_nxt != psc_pkg::PSC_PULSE);
            st.done <= (state_nxt == psc_pkg::PSC_DONE);
            clk_q_r <= shift_clock;
        end
    end

    property p_sync_hold;
        @(posedge pclk) disable iff (!presetn)
        (ce && !sync_n) |=> (st.pos == '0 && state_r == psc_pkg::PSC_SCAN && st.eos_n);
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("pointer not held at start by sync");

    property p_advance;
        @(posedge pclk) disable iff (!presetn)
        (ce && sync_n && enable && fall && state_r == psc_pkg::PSC_SCAN && st.pos < last)
        |=> st.pos == $past(st.pos) + $past(step);
    endproperty
    a_advance: assert property (p_advance) else $error("pointer did not step on falling edge");

    property p_eos_pulse;
        @(posedge pclk) disable iff (!presetn)
        (ce && sync_n && state_r == psc_pkg::PSC_WAIT && rise)
        |=> !st.eos_n ##0 (st.eos_n || state_r == psc_pkg::PSC_PULSE);
    endproperty
    a_eos_pulse: assert property (p_eos_pulse) else $error("end of scan not low in first pulse");

endmodule : psc_pointer

`default_nettype wire

// [core/psc_top.sv]
// pixel array scan control: row and column pointers with apb access
//
// Behaviour
// - right row sync low holds the right row pointer at its start.
// - right row pointer advances one row per falling right row clock edge.
// - right end-of-scan low during first right clock pulse after last row.
// - column sync low holds the column pointer at its start.
// - column pointer steps one column per falling column clock edge.
// - column end-of-scan low during first column pulse after last column.
// - left row sync low returns the left row pointer to start.
// - left row pointer advances per falling left clock edge, independently.
// - left end-of-scan low during first left clock pulse after last row.
// - track-and-hold holds at one, tracks at zero.
// - column amplifiers calibrate while calibrate input is one.
// - row select high connects the chosen pointer's row to readout.
// - row reset high resets the chosen pointer's row.
// - side choice one picks left pointer, zero picks right pointer.
// - subsample one scans every fourth row and column; zero scans all unless the control subsample bit is set.
`include "psc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module psc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire psc_pkg::psc_pins_t pins,
    output logic right_row_end_of_scan_n,
    output logic left_row_end_of_scan_n,
    output logic column_end_of_scan_n,
    output logic [10:0] row_addr,
    output logic row_select_active,
    output logic row_reset_active,
    output logic [10:0] column_addr,
    output logic column_track_hold_active,
    output logic column_amp_calibrate_active
);

    // ************************************************************
    // pin synchronisation
    // ************************************************************
    psc_pkg::psc_pins_t pin_s;
    logic [`PSC_PIN_W-1:0] pin_s_bits;

    psc_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .din(pins),
        .dout(pin_s_bits)
    );

    assign pin_s = psc_pkg::psc_pins_t'(pin_s_bits);

    // ************************************************************
    // control register state
    // ************************************************************
    logic [1:0] ctrl_r;
    logic [2:0] early_r;
    logic [2:0] early_set;
    logic [2:0] early_clr;
    logic [15:0] frames_r;
    logic [2:0] sync_q_r;
    logic right_done_q_r;
    logic scan_en;
    logic sub_eff;

    assign scan_en = ctrl_r[`PSC_CTRL_EN_BIT];
    // software can force viewfinder mode even if the pin is low
    assign sub_eff = pin_s.viewfinder_subsample | ctrl_r[`PSC_CTRL_SUB_BIT];

    // ************************************************************
    // pointers
    // ************************************************************
    psc_pkg::psc_ptr_st_t right_st;
    psc_pkg::psc_ptr_st_t left_st;
    psc_pkg::psc_ptr_st_t col_st;

    psc_pointer #(
        .LENGTH(`PSC_ROWS)
    ) u_right (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .enable(scan_en),
        .subsample(sub_eff),
        .sync_n(pin_s.right_row_sync_n),
        .shift_clock(pin_s.right_row_shift_clock),
        .st(right_st)
    );

    psc_pointer #(
        .LENGTH(`PSC_ROWS)
    ) u_left (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .enable(scan_en),
        .subsample(sub_eff),
        .sync_n(pin_s.left_row_sync_n),
        .shift_clock(pin_s.left_row_shift_clock),
        .st(left_st)
    );

    psc_pointer #(
        .LENGTH(`PSC_COLS)
    ) u_col (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .enable(scan_en),
        .subsample(sub_eff),
        .sync_n(pin_s.column_sync_n),
        .shift_clock(pin_s.column_shift_clock),
        .st(col_st)
    );

    assign right_row_end_of_scan_n = right_st.eos_n;
    assign left_row_end_of_scan_n = left_st.eos_n;
    assign column_end_of_scan_n = col_st.eos_n;

    // ************************************************************
    // row and column drive
    // ************************************************************
    // one cycle of register after the synchroniser keeps outputs glitch free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_addr <= 11'h000;
            row_select_active <= 1'b0;
            row_reset_active <= 1'b0;
        end else if (ce) begin
            row_addr <= pin_s.row_side_left ? left_st.pos : right_st.pos;
            row_select_active <= pin_s.row_select;
            row_reset_active <= pin_s.row_reset;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            column_addr <= 11'h000;
            column_track_hold_active <= 1'b0;
            column_amp_calibrate_active <= 1'b0;
        end else if (ce) begin
            column_addr <= col_st.pos;
            column_track_hold_active <= pin_s.column_track_hold;
            column_amp_calibrate_active <= pin_s.column_amp_calibrate;
        end
    end

    // ************************************************************
    // early sync detection and frame count
    // ************************************************************
    // a sync falling while a scan is still mid-way is flagged, not refused
    function automatic logic early_edge(input logic prev_n, input logic now_n,
                                        input psc_pkg::psc_ptr_st_t s);
        early_edge = prev_n && !now_n && !s.done && (s.pos != 11'h000);
    endfunction : early_edge

    assign early_set[0] = early_edge(sync_q_r[0], pin_s.right_row_sync_n, right_st);
    assign early_set[1] = early_edge(sync_q_r[1], pin_s.left_row_sync_n, left_st);
    assign early_set[2] = early_edge(sync_q_r[2], pin_s.column_sync_n, col_st);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_q_r <= 3'h7;
        end else if (ce) begin
            sync_q_r <= {pin_s.column_sync_n, pin_s.left_row_sync_n, pin_s.right_row_sync_n};
        end
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            early_r <= 3'h0;
        end else if (ce) begin
            early_r <= (early_r & ~early_clr) | early_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            right_done_q_r <= 1'b0;
            frames_r <= 16'h0000;
        end else if (ce) begin
            right_done_q_r <= right_st.done;
            if (right_st.done && !right_done_q_r) begin
                frames_r <= frames_r + 16'h0001;
            end
        end
    end

    // ************************************************************
    // apb slave
    // ************************************************************
    logic setup;
    logic access;
    logic [9:0] word;
    logic [9:0] word_q_r;
    logic mapped;
    logic [31:0] rd_mux;

    assign setup = psel && !penable;
    assign access = psel && penable && pready;
    assign word = paddr[11:2];

    function automatic logic is_mapped(input logic [9:0] w);
        is_mapped = (w == `PSC_OFS_CTRL) || (w == `PSC_OFS_STATUS) || (w == `PSC_OFS_ROWPOS)
                    || (w == `PSC_OFS_COLPOS) || (w == `PSC_OFS_FRAMES);
    endfunction : is_mapped

    assign mapped = is_mapped(word);
    assign early_clr = (access && pwrite && word_q_r == `PSC_OFS_STATUS)
                       ? pwdata[`PSC_STAT_EARLY_LSB+2:`PSC_STAT_EARLY_LSB] : 3'h0;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (word)
            `PSC_OFS_CTRL: begin
                rd_mux = {30'h0000_0000, ctrl_r};
            end
            `PSC_OFS_STATUS: begin
                rd_mux = {21'h00_0000, early_r, 1'b0, sub_eff, col_st.done, left_st.done,
                          right_st.done, col_st.eos_n, left_st.eos_n, right_st.eos_n};
            end
            `PSC_OFS_ROWPOS: begin
                rd_mux = {5'h00, right_st.pos, 5'h00, left_st.pos};
            end
            `PSC_OFS_COLPOS: begin
                rd_mux = {21'h00_0000, col_st.pos};
            end
            `PSC_OFS_FRAMES: begin
                rd_mux = {16'h0000, frames_r};
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    // answer registered in setup so the access phase always has one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            word_q_r <= 10'h000;
        end else if (ce) begin
            pready <= setup;
            pslverr <= setup && !mapped;
            word_q_r <= word;
            if (setup && !pwrite) begin
                prdata <= rd_mux;
            end else if (access) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `PSC_CTRL_RST;
        end else if (ce) begin
            if (access && pwrite && word_q_r == `PSC_OFS_CTRL) begin
                ctrl_r <= pwdata[1:0];
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_track_hold;
        @(posedge pclk) disable iff (!presetn)
        ce |=> column_track_hold_active == $past(pin_s.column_track_hold);
    endproperty
    a_track_hold: assert property (p_track_hold) else $error("track-hold drive lost");

    property p_calibrate;
        @(posedge pclk) disable iff (!presetn)
        ce |=> column_amp_calibrate_active == $past(pin_s.column_amp_calibrate);
    endproperty
    a_calibrate: assert property (p_calibrate) else $error("calibrate drive mismatch");

    property p_select;
        @(posedge pclk) disable iff (!presetn)
        ce |=> row_select_active == $past(pin_s.row_select);
    endproperty
    a_select: assert property (p_select) else $error("row select active without input");

    property p_reset;
        @(posedge pclk) disable iff (!presetn)
        ce |=> row_reset_active == $past(pin_s.row_reset);
    endproperty
    a_reset: assert property (p_reset) else $error("row reset drive mismatch");

    property p_side;
        @(posedge pclk) disable iff (!presetn)
        ce |=> row_addr == ($past(pin_s.row_side_left) ? $past(left_st.pos) : $past(right_st.pos));
    endproperty
    a_side: assert property (p_side) else $error("row address from wrong pointer");

    property p_subsample;
        @(posedge pclk) disable iff (!presetn)
        (sub_eff && col_st.pos[1:0] == 2'h0) ##1 sub_eff |-> col_st.pos[1:0] == 2'h0;
    endproperty
    a_subsample: assert property (p_subsample) else $error("subsampled column off grid");

endmodule : psc_top

`default_nettype wire

// [tb/psc_ctrl_model.sv]
// behavioural timing controller that drives the scan control pins
`timescale 1ns/1ps
`default_nettype none

module psc_ctrl_model (
    input wire logic pclk,
    output var psc_pkg::psc_pins_t pins
);
    // each level lasts 8 pclk, safely above the 3 cycle pin-to-pointer latency
    localparam int LVL = 8;

    // ************************************************************
    // idle: syncs high, shift clocks low, strobes low
    // ************************************************************
    initial begin
        pins = 12'hA80;
    end

    // idx 0 right row, 1 left row, 2 column; clk 1 picks the shift clock
    task automatic level(input int idx, input int clk, input logic v);
        pins[11 - 2 * idx - clk] <= v;
        repeat (LVL) @(posedge pclk);
    endtask : level

    task automatic sync(input int idx);
        level(idx, 0, 1'b0);
        level(idx, 0, 1'b1);
    endtask : sync

    task automatic clocks(input int idx, input int n);
        repeat (n) begin
            level(idx, 1, 1'b1);
            level(idx, 1, 1'b0);
        end
    endtask : clocks

    // select, reset, side, track-hold, calibrate, subsample
    task automatic strobes(input logic [5:0] v);
        pins[5:0] <= v;
        repeat (LVL) @(posedge pclk);
    endtask : strobes
endmodule : psc_ctrl_model

`default_nettype wire

// [tb/pixel_array_scan_control_bench.sv]
// self-checking testbench of the pixel array scan control block
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module pixel_array_scan_control_bench;
    logic pclk;
    logic presetn;
    logic ce;
    logic psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rng, v;
    logic pready, pslverr, eos_r, eos_l, eos_c, sel_a, rst_a, th_a, cal_a;
    logic [10:0] row_addr, column_addr;
    psc_pkg::psc_pins_t pins;
    logic look;
    logic [1:0] look_sel;
    logic [32:0] q[$];
    logic [32:0] note, obs;
    int miscompares, num_checks, n;

    // ************************************************************
    // clock, design and controller
    // ************************************************************
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    psc_top i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins), .right_row_end_of_scan_n(eos_r), .left_row_end_of_scan_n(eos_l),
        .column_end_of_scan_n(eos_c), .row_addr(row_addr), .row_select_active(sel_a),
        .row_reset_active(rst_a), .column_addr(column_addr), .column_track_hold_active(th_a),
        .column_amp_calibrate_active(cal_a));

    psc_ctrl_model i_ctrl (.pclk(pclk), .pins(pins));

    function automatic logic [31:0] xorshift();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xorshift

    // ************************************************************
    // monitor: oldest note against each result that appears
    // ************************************************************
    always_comb begin
        case (look_sel)
            2'h0: obs = {30'h0, eos_r, eos_l, eos_c};
            2'h1: obs = {22'h0, row_addr};
            2'h2: obs = {22'h0, column_addr};
            default: obs = {29'h0, sel_a, rst_a, th_a, cal_a};
        endcase
    end

    always @(posedge pclk) begin
        if (presetn === 1'b1 && look === 1'b1) begin
            note = q.pop_front();
            `CHK(obs, note)
        end else if (presetn === 1'b1 && psel && penable && !pwrite && pready === 1'b1) begin
            note = q.pop_front();
            `CHK({pslverr, prdata}, note)
        end
    end

    // ************************************************************
    // apb master and note tasks
    // ************************************************************
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no fixed wait: only the watchdog ends a hung transfer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
        q.push_back({err, e});
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic look_at(input logic [1:0] s, input logic [32:0] e);
        q.push_back(e);
        look_sel <= s;
        look <= 1'b1;
        @(posedge pclk);
        look <= 1'b0;
        @(posedge pclk);
    endtask : look_at

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    // ************************************************************
    // watchdog: the scans need about 30k cycles
    // ************************************************************
    initial begin
        repeat (60000) @(posedge pclk);
        miscompares++;
        end_of_test();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        rng = 32'h000122C7;
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        look = 1'b0;
        look_sel = 2'h0;
        miscompares = 0;
        num_checks = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'h000, 32'h00000001, 1'b0);
        rd(12'h004, 32'h00000007, 1'b0);
        rd(12'hFFC, 32'h00000000, 1'b1);
        // clocks while sync is held low must not move the pointer
        i_ctrl.level(0, 0, 1'b0);
        i_ctrl.clocks(0, 3);
        look_at(2'h1, 33'h0);
        i_ctrl.level(0, 0, 1'b1);
        i_ctrl.clocks(0, 1023);
        look_at(2'h1, 33'h3FF);
        rd(12'h008, 32'h03FF0000, 1'b0);
        // the next fall leaves the pointer on the last row; the pulse after it is flagged
        i_ctrl.clocks(0, 1);
        i_ctrl.level(0, 1, 1'b1);
        look_at(2'h0, 33'h3);
        i_ctrl.level(0, 1, 1'b0);
        look_at(2'h0, 33'h7);
        rd(12'h010, 32'h00000001, 1'b0);
        // full resolution column walk of random length
        n = int'(xorshift() % 32'd60) + 1;
        i_ctrl.sync(2);
        i_ctrl.clocks(2, n);
        look_at(2'h2, 33'(n));
        // viewfinder mode, right then left pointer on the strobes
        i_ctrl.strobes(6'h01);
        i_ctrl.sync(0);
        i_ctrl.sync(1);
        i_ctrl.clocks(1, 255);
        look_at(2'h1, 33'h0);
        i_ctrl.strobes(6'h09);
        look_at(2'h1, 33'h3FC);
        i_ctrl.clocks(1, 1);
        i_ctrl.level(1, 1, 1'b1);
        look_at(2'h0, 33'h5);
        i_ctrl.level(1, 1, 1'b0);
        i_ctrl.sync(2);
        i_ctrl.clocks(2, 319);
        look_at(2'h2, 33'h4FC);
        i_ctrl.clocks(2, 1);
        i_ctrl.level(2, 1, 1'b1);
        look_at(2'h0, 33'h6);
        i_ctrl.level(2, 1, 1'b0);
        for (int i = 0; i < 8; i++) begin
            v = xorshift();
            i_ctrl.strobes(v[5:0]);
            look_at(2'h3, {29'h0, v[5], v[4], v[2], v[1]});
        end
        // scan enable off freezes the pointer, on lets it run again
        i_ctrl.strobes(6'h00);
        apb(1'b1, 12'h000, 32'h0);
        i_ctrl.sync(2);
        i_ctrl.clocks(2, 2);
        look_at(2'h2, 33'h0);
        apb(1'b1, 12'h000, 32'h1);
        i_ctrl.clocks(2, 2);
        look_at(2'h2, 33'h2);
        // clock enable low: pin edges are lost, the pointer stays put
        ce <= 1'b0;
        i_ctrl.clocks(2, 2);
        ce <= 1'b1;
        look_at(2'h2, 33'h2);
        i_ctrl.clocks(2, 1);
        look_at(2'h2, 33'h3);
        end_of_test();
    end
endmodule : pixel_array_scan_control_bench

`default_nettype wire
